// File: core/rsg_map.svh
`ifndef RSG_MAP_SVH
`define RSG_MAP_SVH

// clock rate and supervisor charge delay
`define RSG_REF_CLK_KHZ     25000
`define RSG_CHARGE_TIME_US  100
`define RSG_CHARGE_CYCLES   ((`RSG_CHARGE_TIME_US * `RSG_REF_CLK_KHZ + 999) / 1000)
`define RSG_CHARGE_W        12

// watchdog counter: twenty stages, the top one is the trip output
`define RSG_WDOG_W          20
`define RSG_WDOG_STAGE      19

// bus geometry
`define RSG_LOW_ADDR_W      8
`define RSG_ROM_ADDR_W      13
`define RSG_RAM_DATA_W      4
`define RSG_RAM_DEPTH       256
`define RSG_PORT_HI_W       4
`define RSG_PORT_BIT_23     3

// apb register offsets (byte addresses)
`define RSG_APB_ADDR_W      12
`define RSG_REG_CTRL        12'h000
`define RSG_REG_STATUS      12'h004
`define RSG_REG_COUNT       12'h008
`define RSG_REG_CAUSE       12'h00C

// control fields
`define RSG_CTRL_INHIBIT    0
`define RSG_CTRL_RESET      2'h0

// status fields
`define RSG_ST_RESET_N      0
`define RSG_ST_SUPPLY_OK    1
`define RSG_ST_STAGE        2
`define RSG_ST_RAM_LO_N     3
`define RSG_ST_CAL_SW       4
`define RSG_ST_STATE_LSB    8

// reset cause fields, write one to clear
`define RSG_CAUSE_SUPPLY    0
`define RSG_CAUSE_WDOG      1
`define RSG_CAUSE_W         2
`define RSG_CAUSE_RESET     2'h1

`endif

// File: core/rsg_pkg.sv
package rsg_pkg;

  `include "rsg_map.svh"

  // apb request from the master
  typedef struct packed {
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [`RSG_APB_ADDR_W-1:0] paddr;
    logic [31:0]                pwdata;
  } rsg_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } rsg_apb_rsp_t;

  // pins from the controller and the board, all asynchronous to ref_clk_i
  typedef struct packed {
    logic                       ale;
    logic                       rd_n;
    logic                       wr_n;
    logic                       prog_fetch_strobe_n_n;
    logic                       scan;
    logic                       test_req;
    logic                       supply_ok;
    logic                       cal_sw;
    logic                       pb14;
    logic [`RSG_PORT_HI_W-1:0]  pb20;
    logic [`RSG_LOW_ADDR_W-1:0] data;
  } rsg_pins_t;

  // supervisor phases
  typedef enum logic [1:0] {
    RSG_SUP_HOLD   = 2'b00,
    RSG_SUP_CHARGE = 2'b01,
    RSG_SUP_RUN    = 2'b10
  } rsg_sup_t;

  // watchdog state
  typedef struct packed {
    logic [`RSG_WDOG_W-1:0] count;
    logic                   stage;
  } rsg_wdog_state_t;

  // top level state
  typedef struct packed {
    rsg_pins_t                                        s1;
    rsg_pins_t                                        s2;
    logic                                             ale_d;
    logic                                             wr_d;
    logic                                             scan_d;
    logic                                             stage_d;
    rsg_sup_t                                         sup;
    logic [`RSG_CHARGE_W-1:0]                         charge;
    logic                                             rst_n;
    logic                                             ss_n;
    logic                                             ram_hi;
    logic                                             ram_lo_n;
    logic                                             prog_fetch_strobe_n_n;
    logic [`RSG_LOW_ADDR_W-1:0]                       low_addr;
    logic [`RSG_ROM_ADDR_W-1:0]                       rom_addr;
    logic [`RSG_RAM_DATA_W-1:0]                       wdata;
    logic [`RSG_RAM_DATA_W-1:0]                       rdata;
    logic                                             data_oe;
    logic                                             od;
    logic                                             rw_n;
    logic                                             inhibit;
    logic [`RSG_CAUSE_W-1:0]                          cause;
    rsg_apb_rsp_t                                     rsp;
    logic [`RSG_RAM_DEPTH-1:0][`RSG_RAM_DATA_W-1:0]   ram;
  } rsg_state_t;

endpackage

// File: core/rsg_top.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "rsg_map.svh"

module rsg_top
(
  // clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        resetn_i,
  // apb slave
  input  wire rsg_pkg::rsg_apb_req_t       apb_req_i,
  output rsg_pkg::rsg_apb_rsp_t            apb_rsp_o,
  // controller bus and ports
  input  wire logic                        ale_i,
  input  wire logic [`RSG_LOW_ADDR_W-1:0]  bus_data_i,
  output logic [`RSG_RAM_DATA_W-1:0]       bus_data_o,
  output logic                             bus_data_oe_o,
  input  wire logic                        rd_n_i,
  input  wire logic                        wr_n_i,
  input  wire logic                        prog_fetch_strobe_n_n_i,
  input  wire logic                        port_bit_14_i,
  input  wire logic [`RSG_PORT_HI_W-1:0]   port_bit_20_i,
  input  wire logic                        scan_line_i,
  // board level inputs
  input  wire logic                        test_request_i,
  input  wire logic                        supply_ok_i,
  input  wire logic                        cal_switch_i,
  // controller supervision
  output logic                             ctrl_reset_n_o,
  output logic                             single_step_n_o,
  // memory side
  output logic                             prog_fetch_strobe_n_o,
  output logic [`RSG_ROM_ADDR_W-1:0]       rom_addr_o,
  output logic [`RSG_LOW_ADDR_W-1:0]       low_addr_o,
  output logic                             ram_enable_hi_o,
  output logic                             ram_enable_lo_n_o,
  output logic                             ram_output_disable_o,
  output logic                             ram_rw_n_o
);
  import rsg_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam logic [`RSG_CHARGE_W-1:0] CHARGE_CYCLES = `RSG_CHARGE_W'(`RSG_CHARGE_CYCLES);

  logic [1:0]              rst_q;
  logic                    rst_n;
  rsg_state_t              st;
  rsg_state_t              next_st;
  rsg_pins_t               pins;
  logic                    ale_fall;
  logic                    ale_rise;
  logic                    wr_rise;
  logic                    scan_edge;
  logic                    wdog_clear;
  logic [`RSG_WDOG_W-1:0]  wdog_count;
  logic                    wdog_stage;
  logic                    hold;
  logic                    next_rst_n;
  logic                    ram_sel;
  logic                    apb_access;
  logic [31:0]             status;

  //////////////////////////////////////////////////////////////////////////////
  // reset release: two flops so every flop leaves reset on the same edge

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_q <= 2'h0;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // pin bundle, synchronised through st.s1 and st.s2

  assign pins.ale       = ale_i;
  assign pins.rd_n      = rd_n_i;
  assign pins.wr_n      = wr_n_i;
  assign pins.prog_fetch_strobe_n_n    = prog_fetch_strobe_n_n_i;
  assign pins.scan      = scan_line_i;
  assign pins.test_req  = test_request_i;
  assign pins.supply_ok = supply_ok_i;
  assign pins.cal_sw    = cal_switch_i;
  assign pins.pb14      = port_bit_14_i;
  assign pins.pb20      = port_bit_20_i;
  assign pins.data      = bus_data_i;

  // edges only ever look at the second stage and a delayed copy of it
  assign ale_fall  = st.ale_d & ~st.s2.ale;
  assign ale_rise  = ~st.ale_d & st.s2.ale;
  assign wr_rise   = ~st.wr_d & st.s2.wr_n;
  assign scan_edge = st.scan_d ^ st.s2.scan;

  // a stuck scan line gives no edge, so it cannot mask a hung controller
  assign wdog_clear = scan_edge & ~st.s2.test_req & ~st.inhibit;

  //////////////////////////////////////////////////////////////////////////////
  // watchdog counter, ticked once per latch strobe cycle

  rsg_wdog u_wdog
  (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .tick_i  (ale_rise),
    .clear_i (wdog_clear),
    .count_o (wdog_count),
    .stage_o (wdog_stage)
  );

  //////////////////////////////////////////////////////////////////////////////
  // supervisor hold condition and bus decode

  assign hold       = ~st.s2.supply_ok | wdog_stage;
  assign ram_sel    = st.ram_hi & ~st.ram_lo_n;
  assign apb_access = apb_req_i.psel & apb_req_i.penable & ~st.rsp.pready;

  // status word shows live supervisor and memory gating state
  always_comb
  begin
    status = 32'h0000_0000;
    status[`RSG_ST_RESET_N]   = st.rst_n;
    status[`RSG_ST_SUPPLY_OK] = st.s2.supply_ok;
    status[`RSG_ST_STAGE]     = wdog_stage;
    status[`RSG_ST_RAM_LO_N]  = st.ram_lo_n;
    status[`RSG_ST_CAL_SW]    = st.s2.cal_sw;
    status[`RSG_ST_STATE_LSB +: 2] = st.sup;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_st    = st;
    next_rst_n = 1'b0;

    // synchroniser chain and edge history
    next_st.s1      = pins;
    next_st.s2      = st.s1;
    next_st.ale_d   = st.s2.ale;
    next_st.wr_d    = st.s2.wr_n;
    next_st.scan_d  = st.s2.scan;
    next_st.stage_d = wdog_stage;

    // supervisor: the charge delay restarts on every new hold
    case (st.sup)
      RSG_SUP_HOLD:
      begin
        next_st.charge = '0;
        if (!hold)
        begin
          next_st.sup = RSG_SUP_CHARGE;
        end
      end
      RSG_SUP_CHARGE:
      begin
        if (hold)
        begin
          next_st.sup = RSG_SUP_HOLD;
        end
        else if (st.charge == CHARGE_CYCLES)
        begin
          next_st.sup = RSG_SUP_RUN;
        end
        else
        begin
          next_st.charge = st.charge + `RSG_CHARGE_W'(1);
        end
      end
      RSG_SUP_RUN:
      begin
        if (hold)
        begin
          next_st.sup = RSG_SUP_HOLD;
        end
      end
      default:
      begin
        next_st.sup = RSG_SUP_HOLD;
      end
    endcase

    // reset and the ram high enable fall in the same cycle as the hold
    next_rst_n     = (next_st.sup == RSG_SUP_RUN);
    next_st.rst_n  = next_rst_n;
    next_st.ss_n   = next_rst_n;
    next_st.ram_hi = next_rst_n;
    next_st.prog_fetch_strobe_n_n = st.s2.prog_fetch_strobe_n_n | ~next_rst_n;

    // address latch and low ram enable, captured at the strobe's fall
    if (ale_fall)
    begin
      next_st.low_addr = st.s2.data;
      next_st.ram_lo_n = st.s2.pb20[`RSG_PORT_BIT_23];
      next_st.rom_addr = {st.s2.pb14, st.s2.pb20, st.s2.data};
    end

    // ram read: output disable follows the read strobe
    next_st.od      = st.s2.rd_n;
    next_st.data_oe = ~st.s2.rd_n & ram_sel;
    next_st.rdata   = st.ram[st.low_addr];

    // ram write: strobe only reaches the ram with the cal switch on
    next_st.rw_n = ~(st.s2.cal_sw & ~st.s2.wr_n);
    if (!st.s2.wr_n)
    begin
      next_st.wdata = st.s2.data[`RSG_RAM_DATA_W-1:0];
    end
    if (wr_rise && st.s2.cal_sw && ram_sel)
    begin
      next_st.ram[st.low_addr] = st.wdata;
    end

    // apb: answer in the second access cycle, then drop pready
    next_st.rsp.pready  = apb_access;
    next_st.rsp.pslverr = 1'b0;
    next_st.rsp.prdata  = 32'h0000_0000;
    if (apb_access)
    begin
      case (apb_req_i.paddr)
        `RSG_REG_CTRL:
        begin
          next_st.rsp.prdata[`RSG_CTRL_INHIBIT] = st.inhibit;
          if (apb_req_i.pwrite)
          begin
            next_st.inhibit = apb_req_i.pwdata[`RSG_CTRL_INHIBIT];
          end
        end
        `RSG_REG_STATUS:
        begin
          next_st.rsp.prdata = status;
        end
        `RSG_REG_COUNT:
        begin
          next_st.rsp.prdata[`RSG_WDOG_W-1:0] = wdog_count;
        end
        `RSG_REG_CAUSE:
        begin
          next_st.rsp.prdata[`RSG_CAUSE_W-1:0] = st.cause;
          if (apb_req_i.pwrite)
          begin
            next_st.cause = st.cause & ~apb_req_i.pwdata[`RSG_CAUSE_W-1:0];
          end
        end
        default:
        begin
          next_st.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // cause flags are set after the clear so a new event is never lost
    if (!st.s2.supply_ok)
    begin
      next_st.cause[`RSG_CAUSE_SUPPLY] = 1'b1;
    end
    if (wdog_stage && !st.stage_d)
    begin
      next_st.cause[`RSG_CAUSE_WDOG] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; reset values are constants only

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st           <= '0;
      st.s1.rd_n   <= 1'b1;
      st.s1.wr_n   <= 1'b1;
      st.s1.prog_fetch_strobe_n_n <= 1'b1;
      st.s2.rd_n   <= 1'b1;
      st.s2.wr_n   <= 1'b1;
      st.s2.prog_fetch_strobe_n_n <= 1'b1;
      st.wr_d      <= 1'b1;
      st.sup       <= RSG_SUP_HOLD;
      st.prog_fetch_strobe_n_n    <= 1'b1;
      st.ram_lo_n  <= 1'b1;
      st.od        <= 1'b1;
      st.rw_n      <= 1'b1;
      st.inhibit   <= 1'(`RSG_CTRL_RESET);
      st.cause     <= `RSG_CAUSE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from the state register

  assign apb_rsp_o             = st.rsp;
  assign ctrl_reset_n_o        = st.rst_n;
  assign single_step_n_o       = st.ss_n;
  assign prog_fetch_strobe_n_o = st.prog_fetch_strobe_n_n;
  assign rom_addr_o            = st.rom_addr;
  assign low_addr_o            = st.low_addr;
  assign ram_enable_hi_o       = st.ram_hi;
  assign ram_enable_lo_n_o     = st.ram_lo_n;
  assign ram_output_disable_o  = st.od;
  assign ram_rw_n_o            = st.rw_n;
  assign bus_data_o            = st.rdata;
  assign bus_data_oe_o         = st.data_oe;

endmodule

// File: core/rsg_wdog.sv
`timescale 1ns/1ps
`include "rsg_map.svh"

module rsg_wdog
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // events
  input  wire logic                   tick_i,
  input  wire logic                   clear_i,
  // state
  output logic [`RSG_WDOG_W-1:0]      count_o,
  output logic                        stage_o
);
  import rsg_pkg::*;

  rsg_wdog_state_t st;
  rsg_wdog_state_t next_st;

  //////////////////////////////////////////////////////////////////////////////
  // counter: a clear wins over a tick, wrapping lets the top stage fall again
  always_comb
  begin
    next_st = st;
    if (clear_i)
    begin
      next_st.count = '0;
    end
    else if (tick_i)
    begin
      next_st.count = st.count + `RSG_WDOG_W'(1);
    end
    next_st.stage = next_st.count[`RSG_WDOG_STAGE];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign count_o = st.count;
  assign stage_o = st.stage;

endmodule

// File: test/rsg_cpu_model.sv
`timescale 1ns/1ps

module rsg_cpu_model
(
  // clock and bus wire
  input  wire logic       clk_i,
  input  wire logic [7:0] wire_i,
  // controller pins
  output logic            ale_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            prog_fetch_strobe_n_n_o,
  output logic            pb14_o,
  output logic            scan_o,
  output logic [3:0]      pb20_o,
  output logic [7:0]      data_o
);
  // idle pins
  initial
  begin
    {ale_o, pb14_o, scan_o, pb20_o, data_o} = '0;
    {rd_n_o, wr_n_o, prog_fetch_strobe_n_n_o} = 3'h7;
  end

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // address held well past the latch fall, the block samples through syncs
  task automatic latch(input logic [7:0] a, input logic p23);
    data_o <= a;
    pb20_o <= {p23, 3'h2};
    pb14_o <= 1'h1;
    ale_o  <= 1'h1;
    waitc(4);
    ale_o  <= 1'h0;
    waitc(8);
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      ale_o <= 1'h1;
      waitc(4);
      ale_o <= 1'h0;
      waitc(4);
    end
  endtask

  // keyboard scan edge
  task automatic toggle();
    scan_o <= ~scan_o;
    waitc(6);
  endtask

  // released data lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic p23, input logic [7:0] d);
    latch(a, p23);
    data_o <= d;
    wr_n_o <= 1'h0;
    waitc(5);
    wr_n_o <= 1'h1;
    waitc(5);
    data_o <= ~d;
    waitc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic p23, output logic [3:0] q);
    latch(a, p23);
    data_o <= ~a;
    rd_n_o <= 1'h0;
    waitc(6);
    @(negedge clk_i);
    q = wire_i[3:0];
    @(posedge clk_i);
    rd_n_o <= 1'h1;
    waitc(6);
  endtask
endmodule

// File: test/rsg_top_assertions.sv
`timescale 1ns/1ps
`include "rsg_map.svh"

module rsg_top_assertions
(
  // clock and reset
  input wire logic                       ref_clk_i,
  input wire logic                       resetn_i,
  // controller and board inputs
  input wire logic                       ale_i,
  input wire logic [`RSG_LOW_ADDR_W-1:0] bus_data_i,
  input wire logic                       wr_n_i,
  input wire logic                       port_bit_14_i,
  input wire logic [`RSG_PORT_HI_W-1:0]  port_bit_20_i,
  input wire logic                       supply_ok_i,
  input wire logic                       cal_switch_i,
  // design outputs
  input wire logic                       bus_data_oe_o,
  input wire logic                       ctrl_reset_n_o,
  input wire logic                       single_step_n_o,
  input wire logic                       prog_fetch_strobe_n_o,
  input wire logic [`RSG_ROM_ADDR_W-1:0] rom_addr_o,
  input wire logic [`RSG_LOW_ADDR_W-1:0] low_addr_o,
  input wire logic                       ram_enable_hi_o,
  input wire logic                       ram_enable_lo_n_o,
  input wire logic                       ram_output_disable_o,
  input wire logic                       ram_rw_n_o
);
  logic [11:0] ok_cnt;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // consecutive cycles of raw supply, saturating so a long run cannot wrap
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ok_cnt <= 12'h000;
    else if (!supply_ok_i)
      ok_cnt <= 12'h000;
    else if (ok_cnt != 12'hFFF)
      ok_cnt <= ok_cnt + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_step_follows: assert property (single_step_n_o == ctrl_reset_n_o)
    else $error("single step differs from reset");
  a_fetch_blocked: assert property (!ctrl_reset_n_o [*2] |-> prog_fetch_strobe_n_o)
    else $error("fetch strobe active in reset");
  a_ram_hi_reset: assert property (!ctrl_reset_n_o [*2] |-> !ram_enable_hi_o)
    else $error("ram enable high in reset");
  a_supply_drop: assert property ($fell(supply_ok_i) |-> ##[1:8] !ram_enable_hi_o)
    else $error("ram enable late on supply loss");
  a_no_supply: assert property (!supply_ok_i [*6] |=> !ctrl_reset_n_o)
    else $error("reset released without supply");
  a_charge_wait: assert property ($rose(ctrl_reset_n_o) |-> ok_cnt >= 12'h9C4)
    else $error("reset released before charge delay");
  a_addr_latch: assert property ($fell(ale_i) |-> ##[3:7] (low_addr_o == bus_data_i &&
    rom_addr_o == {port_bit_14_i, port_bit_20_i, bus_data_i}))
    else $error("latched address wrong");
  a_lo_enable: assert property ($fell(ale_i) |-> ##[3:7] ram_enable_lo_n_o == port_bit_20_i[3])
    else $error("low enable not from port bit");
  a_write_gated: assert property (!cal_switch_i [*6] |=> ram_rw_n_o)
    else $error("ram write with switch off");
  a_write_pass: assert property ($fell(wr_n_i) && cal_switch_i |-> ##[2:6] !ram_rw_n_o)
    else $error("ram write strobe not passed");
  a_drive_needs: assert property ((ram_output_disable_o || ram_enable_lo_n_o ||
    !ram_enable_hi_o) [*4] |-> !bus_data_oe_o)
    else $error("ram drives bus while disabled");

  // main scenarios
  c_release: cover property ($rose(ctrl_reset_n_o));
  c_read: cover property (bus_data_oe_o);
  c_write: cover property (!ram_rw_n_o);
endmodule

bind rsg_top rsg_top_assertions rsg_top_assertions_i (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ale_i(ale_i), .bus_data_i(bus_data_i),
  .wr_n_i(wr_n_i), .port_bit_14_i(port_bit_14_i), .port_bit_20_i(port_bit_20_i),
  .supply_ok_i(supply_ok_i), .cal_switch_i(cal_switch_i), .bus_data_oe_o(bus_data_oe_o),
  .ctrl_reset_n_o(ctrl_reset_n_o), .single_step_n_o(single_step_n_o),
  .prog_fetch_strobe_n_o(prog_fetch_strobe_n_o), .rom_addr_o(rom_addr_o),
  .low_addr_o(low_addr_o), .ram_enable_hi_o(ram_enable_hi_o),
  .ram_enable_lo_n_o(ram_enable_lo_n_o), .ram_output_disable_o(ram_output_disable_o),
  .ram_rw_n_o(ram_rw_n_o));

// File: test/rsg_top_tb.sv
`timescale 1ns/1ps

module rsg_top_tb;
  import rsg_pkg::*;

  rsg_apb_req_t req;
  rsg_apb_rsp_t rsp;
  logic         clk, resetn, ale, rd_n, wr_n, prog_fetch_strobe_n_n, pb14, scan, test_req, supply, cal;
  logic         dut_oe, crst_n, sstep_n, pfetch_n, ram_hi, ram_lo_n, ram_od, ram_rw_n;
  logic [3:0]   pb20, dut_d;
  logic [7:0]   cpu_d, dbus, low_a;
  logic [12:0]  rom_a;
  int           n_fail = 0;
  int           n_tests = 0;

  // the block drives the low nibble only while enabled
  assign dbus = dut_oe ? {cpu_d[7:4], dut_d} : cpu_d;

  rsg_top rsg_top_i (.ref_clk_i(clk), .resetn_i(resetn), .apb_req_i(req), .apb_rsp_o(rsp),
    .ale_i(ale), .bus_data_i(dbus), .bus_data_o(dut_d), .bus_data_oe_o(dut_oe),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .prog_fetch_strobe_n_n_i(prog_fetch_strobe_n_n), .port_bit_14_i(pb14),
    .port_bit_20_i(pb20), .scan_line_i(scan), .test_request_i(test_req),
    .supply_ok_i(supply), .cal_switch_i(cal), .ctrl_reset_n_o(crst_n),
    .single_step_n_o(sstep_n), .prog_fetch_strobe_n_o(pfetch_n), .rom_addr_o(rom_a),
    .low_addr_o(low_a), .ram_enable_hi_o(ram_hi), .ram_enable_lo_n_o(ram_lo_n),
    .ram_output_disable_o(ram_od), .ram_rw_n_o(ram_rw_n));

  rsg_cpu_model rsg_cpu_model_i (.clk_i(clk), .wire_i(dbus), .ale_o(ale), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .prog_fetch_strobe_n_n_o(prog_fetch_strobe_n_n), .pb14_o(pb14), .scan_o(scan), .pb20_o(pb20),
    .data_o(cpu_d));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ready, data and error are all taken at the rising edge that sees ready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'h1 && n < 20);
    chk("apb_ready", 1'h1, rsp.pready);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'h0;
    req.penable <= 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic power_up();
    int n;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("reset_held", 1'h0, crst_n);
    chk("step_low", 1'h0, sstep_n);
    chk("fetch_off", 1'h1, pfetch_n);
    chk("ram_hi_off", 1'h0, ram_hi);
    @(posedge clk);
    supply <= 1'h1;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (crst_n !== 1'h1 && n < 3000);
    chk("charge_wait", 1'h1, n >= 2500 && n < 3000);
    chk("ram_hi_on", 1'h1, ram_hi);
    @(posedge clk);
  endtask

  task automatic regs();
    logic [31:0] q;
    logic        e;
    apb(1'h0, 12'h00C, 32'h0, q, e);
    chk("cause_reset", 32'h1, q);
    apb(1'h1, 12'h00C, 32'h1, q, e);
    apb(1'h0, 12'h00C, 32'h0, q, e);
    chk("cause_clear", 32'h0, q);
    apb(1'h1, 12'h000, 32'h1, q, e);
    apb(1'h0, 12'h000, 32'h0, q, e);
    chk("ctrl_rw", 32'h1, q);
    apb(1'h1, 12'h000, 32'h0, q, e);
    apb(1'h0, 12'h004, 32'h0, q, e);
    chk("status_run", 32'h20B, q);
    apb(1'h0, 12'h010, 32'h0, q, e);
    chk("unmapped", 1'h1, e);
  endtask

  task automatic wdog();
    logic [31:0] c, q;
    logic        e;
    apb(1'h0, 12'h008, 32'h0, c, e);
    chk("count_zero", 32'h0, c);
    rsg_cpu_model_i.tick(10);
    apb(1'h0, 12'h008, 32'h0, q, e);
    chk("count_tick", c + 32'hA, q);
    rsg_cpu_model_i.toggle();
    apb(1'h0, 12'h008, 32'h0, q, e);
    chk("count_clear", 32'h0, q);
    rsg_cpu_model_i.tick(3);
    apb(1'h0, 12'h008, 32'h0, q, e);
    chk("count_stuck", 32'h3, q);
    test_req <= 1'h1;
    rsg_cpu_model_i.toggle();
    rsg_cpu_model_i.tick(2);
    apb(1'h0, 12'h008, 32'h0, q, e);
    chk("count_test", 32'h5, q);
    test_req <= 1'h0;
    apb(1'h1, 12'h000, 32'h1, q, e);
    rsg_cpu_model_i.toggle();
    apb(1'h0, 12'h008, 32'h0, q, e);
    chk("count_inhibit", 32'h5, q);
    apb(1'h1, 12'h000, 32'h0, q, e);
  endtask

  task automatic ram();
    logic [3:0] q;
    cal <= 1'h1;
    rsg_cpu_model_i.wr(8'h3C, 1'h0, 8'hFA);
    rsg_cpu_model_i.wr(8'h3D, 1'h0, 8'h05);
    rsg_cpu_model_i.rd(8'h3C, 1'h0, q);
    chk("ram_read", 4'hA, q);
    cal <= 1'h0;
    rsg_cpu_model_i.wr(8'h3C, 1'h0, 8'h06);
    rsg_cpu_model_i.rd(8'h3C, 1'h0, q);
    chk("ram_locked", 4'hA, q);
    rsg_cpu_model_i.rd(8'h3D, 1'h1, q);
    chk("ram_quiet", 4'h2, q);
    @(negedge clk);
    chk("low_addr", 8'h3D, low_a);
    @(posedge clk);
    rsg_cpu_model_i.prog_fetch_strobe_n_n_o <= 1'h0;
    repeat (4) @(posedge clk);
    chk("fetch_run", 1'h0, pfetch_n);
    rsg_cpu_model_i.prog_fetch_strobe_n_n_o <= 1'h1;
  endtask

  // supply loss must drop the ram enable and reset together
  task automatic supply_loss();
    logic [31:0] q;
    logic        e;
    @(posedge clk);
    supply <= 1'h0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("ram_hi_loss", 1'h0, ram_hi);
    chk("reset_loss", 1'h0, crst_n);
    apb(1'h0, 12'h00C, 32'h0, q, e);
    chk("cause_loss", 32'h1, q & 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // hang guard, far beyond the expected run of a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  // main sequence
  initial
  begin
    resetn = 1'h0;
    req = '0;
    {test_req, supply, cal} = 3'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    power_up();
    regs();
    wdog();
    ram();
    supply_loss();
    finish_test();
  end
endmodule
